// ### hw/aoue_pkg.sv
// Purpose: shared constants for the always-on usb/ethernet control block
// Assumes: 8-bit register port, 40 MHz clock
// Notes: offsets are register indices on the plain register port
package aoue_pkg;
    // ==========================================================
    // register port
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_WDIS_EN = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

    // ==========================================================
    // control register fields
    localparam int unsigned BIT_HUB_POLICY = 7;
    localparam int unsigned BIT_WDIS = 6;
    localparam int unsigned BIT_NET1_OFF = 5;
    localparam int unsigned BIT_NET0_OFF = 4;
    localparam int unsigned BIT_ID_SEL = 3;
    localparam int unsigned BIT_HUB_HOLD = 2;
    localparam int unsigned BIT_PADDLE_DIS = 1;
    localparam int unsigned BIT_ONBOARD_DIS = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

    // ==========================================================
    // extra wireless-disable sources
    localparam int unsigned WDIS_SRC_N = 2;
    localparam logic [WDIS_SRC_N-1:0] WDIS_EN_RESET = 2'h0;

    // ==========================================================
    // status register fields
    localparam int unsigned ST_ID_PIN = 0;
    localparam int unsigned ST_HUB_IN_RESET = 1;
    localparam int unsigned ST_WDIS_OUT = 2;
    localparam int unsigned ST_PLAT_RST = 3;
    localparam int unsigned ST_ONBOARD_ON = 4;
    localparam int unsigned ST_PADDLE_ON = 5;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned HUB_POR_NS = 100000;
    localparam int unsigned HUB_POR_CYCLES = (HUB_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POR_CNT_W = 12;
    localparam logic [POR_CNT_W-1:0] POR_CNT_LAST = POR_CNT_W'(HUB_POR_CYCLES - 1);
    localparam logic [POR_CNT_W-1:0] POR_CNT_ZERO = 12'h000;
endpackage : aoue_pkg

// ### hw/aoue_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are slow levels
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module aoue_sync2 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : aoue_sync2

// ### hw/aoue_hub_rst.sv
// Purpose: usb hub reset generation
// Assumes: platRst is synchronised, active high
// Notes: output is active low and registered
`timescale 1ns/100ps
module aoue_hub_rst (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic platRst,
    input wire logic policyEvery,
    input wire logic holdReset,
    output logic hubRstN
);
    // ==========================================================
    // power-on pulse
    logic [aoue_pkg::POR_CNT_W-1:0] porCnt_q;
    logic [aoue_pkg::POR_CNT_W-1:0] porCnt_d;
    logic porDone_q;
    logic porDone_d;
    logic hubRst;

    // only the main reset restarts the pulse, so it happens once
    assign porDone_d = porDone_q | (porCnt_q == aoue_pkg::POR_CNT_LAST);
    assign porCnt_d = porDone_q ? porCnt_q : porCnt_q + 12'h001;

    // platform reset reaches the hub only under the every-reset policy
    assign hubRst = !porDone_q | holdReset | (policyEvery & platRst);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            porCnt_q <= aoue_pkg::POR_CNT_ZERO;
            porDone_q <= 1'b0;
            hubRstN <= 1'b0;
        end else begin
            porCnt_q <= porCnt_d;
            porDone_q <= porDone_d;
            hubRstN <= !hubRst;
        end
    end
endmodule : aoue_hub_rst

// ### hw/aoue_ctrl.sv
// Purpose: always-on control register for usb hub, ethernet and vbus switches
// Assumes: rst_n is the main power-on reset only; platform reset is a pin
// Notes: all board outputs come from flip-flops
//
// Notes on behaviour
// - only the main power-on reset clears the register; platform reset does not.
// - policy 0 resets hub once at power-on; 1 also on every platform reset.
// - bit 6 set asserts wireless-disable to the mini card; clear leaves it to the enabled extra sources.
// - wireless-disable is the OR of bit 6 and every enabled extra source.
// - bit 5 set drives ethernet 1 off input low, turning it off.
// - bit 4 set drives ethernet 0 off input low, turning it off.
// - bit 3 set: on-board vbus follows id pin, disable bit still wins.
// - bit 3 clear: on-board vbus follows only the disable bit.
// - bit 2 set holds the usb hub in reset; clear releases it.
// - bit 1 set disables the shared paddleboard vbus switch enable.
// - bit 0 set disables the on-board vbus switches; clear enables them.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module aoue_ctrl (
    input wire logic clk,
    input wire logic rst_n,

    input wire logic [aoue_pkg::ADDR_W-1:0] regAddr,
    input wire logic [aoue_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [aoue_pkg::DATA_W-1:0] regRdata,

    input wire logic platRstPin_n,
    input wire logic otgIdPin,
    input wire logic [aoue_pkg::WDIS_SRC_N-1:0] extWdisPin,

    output logic hubRstOut_n,
    output logic wirelessDisable,
    output logic net1OffInput_n,
    output logic net0OffInput_n,
    output logic paddleVbusEn,
    output logic onboardVbusEn
);

    // ==========================================================
    // pin synchronisers
    logic platRstSync_n;
    logic otgIdSync;
    logic [aoue_pkg::WDIS_SRC_N-1:0] extWdisSync;

    // platform reset is sampled as data, never used as a flop reset
    aoue_sync2 #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sync_plat (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(platRstPin_n),
        .syncOut(platRstSync_n)
    );

    // id idles high (b-type / nothing), so with bit 3 set power stays off until a-cable seen
    aoue_sync2 #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sync_id (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(otgIdPin),
        .syncOut(otgIdSync)
    );

    aoue_sync2 #(
        .W(aoue_pkg::WDIS_SRC_N),
        .RST_VAL(aoue_pkg::WDIS_EN_RESET)
    ) u_sync_wdis (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(extWdisPin),
        .syncOut(extWdisSync)
    );

    // ==========================================================
    // address decode
    logic selCtrl;
    logic selWdisEn;
    logic selStatus;
    logic wrCtrl;
    logic wrWdisEn;

    assign selCtrl = (regAddr == aoue_pkg::OFF_CTRL);
    assign selWdisEn = (regAddr == aoue_pkg::OFF_WDIS_EN);
    assign selStatus = (regAddr == aoue_pkg::OFF_STATUS);
    assign wrCtrl = regWr & selCtrl;
    assign wrWdisEn = regWr & selWdisEn;

    // ==========================================================
    // control register
    logic [aoue_pkg::DATA_W-1:0] ctrl_q;
    logic [aoue_pkg::DATA_W-1:0] ctrl_d;

    // every field is plain read/write
    assign ctrl_d = wrCtrl ? regWdata : ctrl_q;

    // rst_n is the main power-on reset; sleep and platform reset leave it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= aoue_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==========================================================
    // field views
    logic hubPolicy;
    logic wdisBit;
    logic net1Off;
    logic net0Off;
    logic idSelect;
    logic hubHold;
    logic paddleDis;
    logic onboardDis;

    assign hubPolicy = ctrl_q[aoue_pkg::BIT_HUB_POLICY];
    assign wdisBit = ctrl_q[aoue_pkg::BIT_WDIS];
    assign net1Off = ctrl_q[aoue_pkg::BIT_NET1_OFF];
    assign net0Off = ctrl_q[aoue_pkg::BIT_NET0_OFF];
    assign idSelect = ctrl_q[aoue_pkg::BIT_ID_SEL];
    assign hubHold = ctrl_q[aoue_pkg::BIT_HUB_HOLD];
    assign paddleDis = ctrl_q[aoue_pkg::BIT_PADDLE_DIS];
    assign onboardDis = ctrl_q[aoue_pkg::BIT_ONBOARD_DIS];

    // ==========================================================
    // wireless-disable source enables
    logic [aoue_pkg::WDIS_SRC_N-1:0] wdisEn_q;
    logic [aoue_pkg::WDIS_SRC_N-1:0] wdisEn_d;

    assign wdisEn_d = wrWdisEn ? regWdata[aoue_pkg::WDIS_SRC_N-1:0] : wdisEn_q;

    // kept in the always-on well like the control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdisEn_q <= aoue_pkg::WDIS_EN_RESET;
        end else begin
            wdisEn_q <= wdisEn_d;
        end
    end

    // ==========================================================
    // hub reset
    logic platRstActive;

    assign platRstActive = !platRstSync_n;

    // hold bit doubles as the manual reset under the once-only policy
    aoue_hub_rst u_hub_rst (
        .clk(clk),
        .rst_n(rst_n),
        .platRst(platRstActive),
        .policyEvery(hubPolicy),
        .holdReset(hubHold),
        .hubRstN(hubRstOut_n)
    );

    // ==========================================================
    // board control decode
    logic wdisAny;
    logic otgACable;
    logic onboardOn;
    logic paddleOn;

    assign wdisAny = wdisBit | (|(extWdisSync & wdisEn_q));

    // a-cable grounds id; b-devices are not supported so they get no power
    assign otgACable = !otgIdSync;

    // disable bit overrides the id path in both modes
    assign onboardOn = !onboardDis & (!idSelect | otgACable);

    // one shared enable for both paddleboard switches
    assign paddleOn = !paddleDis;

    // ==========================================================
    // output flops
    // recovery from latch-off relies on software timing the 1 -> 0 pulse;
    // the block adds no minimum-width guard
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wirelessDisable <= 1'b0;
            net1OffInput_n <= 1'b1;
            net0OffInput_n <= 1'b1;
            paddleVbusEn <= 1'b1;
            onboardVbusEn <= 1'b0;
        end else begin
            wirelessDisable <= wdisAny;
            net1OffInput_n <= !net1Off;
            net0OffInput_n <= !net0Off;
            paddleVbusEn <= paddleOn;
            onboardVbusEn <= onboardOn;
        end
    end

    // ==========================================================
    // status view
    logic [aoue_pkg::DATA_W-1:0] statusWord;

    always_comb begin
        statusWord = aoue_pkg::RD_UNMAPPED;
        statusWord[aoue_pkg::ST_ID_PIN] = otgIdSync;
        statusWord[aoue_pkg::ST_HUB_IN_RESET] = !hubRstOut_n;
        statusWord[aoue_pkg::ST_WDIS_OUT] = wirelessDisable;
        statusWord[aoue_pkg::ST_PLAT_RST] = platRstActive;
        statusWord[aoue_pkg::ST_ONBOARD_ON] = onboardVbusEn;
        statusWord[aoue_pkg::ST_PADDLE_ON] = paddleVbusEn;
    end

    // ==========================================================
    // read path
    logic [aoue_pkg::DATA_W-1:0] wdisEnWord;
    logic [aoue_pkg::DATA_W-1:0] rdMux;
    logic [aoue_pkg::DATA_W-1:0] regRdata_d;

    assign wdisEnWord = {{(aoue_pkg::DATA_W-aoue_pkg::WDIS_SRC_N){1'b0}}, wdisEn_q};

    assign rdMux = selCtrl ? ctrl_q :
                   selWdisEn ? wdisEnWord :
                   selStatus ? statusWord :
                   aoue_pkg::RD_UNMAPPED;

    // data stands only in the cycle after the strobe, zero otherwise
    assign regRdata_d = regRd ? rdMux : aoue_pkg::RD_UNMAPPED;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= aoue_pkg::RD_UNMAPPED;
        end else begin
            regRdata <= regRdata_d;
        end
    end

endmodule : aoue_ctrl

// ### sim/aoue_ctrl_monitor.sv
// Purpose: port checks for the always-on control block
// Assumes: bound to aoue_ctrl, one clock
// Notes: board outputs lag a control write by two sampled edges
`timescale 1ns/100ps
module aoue_ctrl_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [aoue_pkg::ADDR_W-1:0] regAddr,
    input wire logic [aoue_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [aoue_pkg::DATA_W-1:0] regRdata,
    input wire logic platRstPin_n,
    input wire logic otgIdPin,
    input wire logic [aoue_pkg::WDIS_SRC_N-1:0] extWdisPin,
    input wire logic hubRstOut_n,
    input wire logic wirelessDisable,
    input wire logic net1OffInput_n,
    input wire logic net0OffInput_n,
    input wire logic paddleVbusEn,
    input wire logic onboardVbusEn
);
    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire ctlWr = regWr && regAddr == aoue_pkg::OFF_CTRL;

    a_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not idle");
    a_net1_follow: assert property (ctlWr |-> ##2 net1OffInput_n == !$past(regWdata[5], 2))
        else $error("net1 off input wrong");
    a_net0_follow: assert property (ctlWr |-> ##2 net0OffInput_n == !$past(regWdata[4], 2))
        else $error("net0 off input wrong");
    a_paddle_follow: assert property (ctlWr |-> ##2 paddleVbusEn == !$past(regWdata[1], 2))
        else $error("paddle enable wrong");
    a_wdis_forced: assert property (ctlWr && regWdata[6] |-> ##2 wirelessDisable)
        else $error("wireless disable not set");
    a_onboard_off: assert property (ctlWr && regWdata[0] |-> ##2 !onboardVbusEn)
        else $error("onboard vbus not off");
    a_id_ignored: assert property (ctlWr && (regWdata & 8'h09) == 8'h00 |-> ##2 onboardVbusEn)
        else $error("onboard vbus not on");
    a_hub_hold: assert property (ctlWr && regWdata[2] |-> ##2 !hubRstOut_n)
        else $error("hub not held in reset");
endmodule : aoue_ctrl_monitor

// ### sim/aoue_board_model.sv
// Purpose: board pins seen by the control block
// Assumes: called right after a rising edge
// Notes: pins are plain levels, no bounce modelled
`timescale 1ns/100ps
module aoue_board_model (
    output logic platRstPin_n,
    output logic otgIdPin,
    output logic [1:0] extWdisPin
);
    // ==========================================================
    // pin drive
    initial begin
        platRstPin_n = 1'b1;
        otgIdPin = 1'b0;
        extWdisPin = 2'h0;
    end
    task setPins(input logic plat, input logic id, input logic [1:0] ext);
        platRstPin_n <= !plat;
        otgIdPin <= id;
        extWdisPin <= ext;
    endtask : setPins
endmodule : aoue_board_model

// ### sim/test_aoue_ctrl.sv
// Purpose: self-checking bench for the always-on control block
// Assumes: 40 MHz clock, power-on hub pulse 4000 cycles
// Notes: expected outputs come from a bench-side equation
`timescale 1ns/100ps
module test_aoue_ctrl;
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic platN, idPin;
    logic [1:0] extPin;
    logic [5:0] outs;
    int nErrors = 0;
    int nTests = 0;
    logic [7:0] tbl [11] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h09, 8'h04, 8'h02,
        8'h01, 8'hff};

    always #12.5 clk = ~clk;
    aoue_board_model i_board (.platRstPin_n(platN), .otgIdPin(idPin), .extWdisPin(extPin));
    aoue_ctrl i_dut (.clk(clk), .rst_n(rstN), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .platRstPin_n(platN),
        .otgIdPin(idPin), .extWdisPin(extPin), .hubRstOut_n(outs[5]),
        .wirelessDisable(outs[4]), .net1OffInput_n(outs[3]), .net0OffInput_n(outs[2]),
        .paddleVbusEn(outs[1]), .onboardVbusEn(outs[0]));

    // ==========================================================
    // helpers
    function automatic logic [7:0] expOut(logic [7:0] c, logic id, logic plat,
        logic [1:0] ext, logic [1:0] en);
        expOut = {2'h0, !(c[2] | (c[7] & plat)), c[6] | (|(ext & en)), !c[5], !c[4], !c[1],
            !c[0] & (!c[3] | !id)};
    endfunction : expOut
    task checkVal(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : checkVal
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 checkVal(regRdata, exp);
    endtask : rd
    task completeRun;
        if (nErrors == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : completeRun

    // ==========================================================
    // scenarios
    task testPowerOn;
        rd(aoue_pkg::OFF_CTRL, 8'h00);
        rd(aoue_pkg::OFF_WDIS_EN, 8'h00);
        rd(4'hf, 8'h00);
        wr(aoue_pkg::OFF_STATUS, 8'hff);
        wr(4'hf, 8'hff);
        rd(aoue_pkg::OFF_CTRL, 8'h00);
        // status ignores the write; hub still in its power-on pulse
        rd(aoue_pkg::OFF_STATUS, 8'h32);
        checkVal({7'h0, outs[5]}, 8'h00);
        repeat (4010) @(posedge clk);
        checkVal({7'h0, outs[5]}, 8'h01);
        rd(aoue_pkg::OFF_STATUS, 8'h30);
    endtask : testPowerOn
    task testFields;
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 2; d++) begin
                for (int k = 0; k < 11; k++) begin
                    i_board.setPins(p[0], d[0], 2'h0);
                    wr(aoue_pkg::OFF_CTRL, tbl[k]);
                    repeat (4) @(posedge clk);
                    rd(aoue_pkg::OFF_CTRL, tbl[k]);
                    checkVal(outs, expOut(tbl[k], d[0], p[0], 2'h0, 2'h0));
                end
            end
        end
    endtask : testFields
    task testWdisOr;
        wr(aoue_pkg::OFF_CTRL, 8'h00);
        for (int e = 0; e < 4; e++) begin
            for (int x = 0; x < 4; x++) begin
                i_board.setPins(1'b0, 1'b0, x[1:0]);
                wr(aoue_pkg::OFF_WDIS_EN, e[7:0]);
                repeat (4) @(posedge clk);
                rd(aoue_pkg::OFF_WDIS_EN, e[7:0]);
                checkVal(outs, expOut(8'h00, 1'b0, 1'b0, x[1:0], e[1:0]));
            end
        end
        wr(aoue_pkg::OFF_WDIS_EN, 8'h00);
    endtask : testWdisOr
    task testRecovery;
        wr(aoue_pkg::OFF_CTRL, 8'h03);
        repeat (40100) @(posedge clk);
        checkVal(outs, expOut(8'h03, 1'b0, 1'b0, 2'h0, 2'h0));
        wr(aoue_pkg::OFF_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        checkVal(outs, expOut(8'h00, 1'b0, 1'b0, 2'h0, 2'h0));
    endtask : testRecovery
    task testMainReset;
        wr(aoue_pkg::OFF_CTRL, 8'hff);
        rstN <= 1'b0;
        repeat (3) @(posedge clk);
        // reset levels: hub held, wireless on, ethernet on, paddle on, onboard off
        checkVal(outs, 8'h0e);
        rstN <= 1'b1;
        rd(aoue_pkg::OFF_CTRL, 8'h00);
        checkVal({7'h0, outs[5]}, 8'h00);
    endtask : testMainReset

    // ==========================================================
    // sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        rstN <= 1'b1;
        testPowerOn();
        testFields();
        testWdisOr();
        testRecovery();
        testMainReset();
        completeRun();
    end
    initial begin
        // about 60000 cycles, well above the ~45000 the scenarios take
        #1500000;
        nErrors++;
        completeRun();
    end
endmodule : test_aoue_ctrl

bind aoue_ctrl aoue_ctrl_monitor i_mon (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .platRstPin_n(platRstPin_n), .otgIdPin(otgIdPin), .extWdisPin(extWdisPin),
    .hubRstOut_n(hubRstOut_n), .wirelessDisable(wirelessDisable),
    .net1OffInput_n(net1OffInput_n), .net0OffInput_n(net0OffInput_n),
    .paddleVbusEn(paddleVbusEn), .onboardVbusEn(onboardVbusEn));
